// File: verilog/sjk_pkg.sv
/*
 * Constants for the bank of single-bit storage elements: register
 * offsets, field positions, element indices and element feature masks.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package sjk_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          DATA_W      = 32;
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_INPUT  = 12'h004;
    localparam logic [11:0] ADDR_STATE  = 12'h008;

    localparam int          CTRL_W      = 3;
    localparam int          CTRL_CLK    = 0;
    localparam int          CTRL_INIT   = 1;
    localparam int          CTRL_INV    = 2;
    localparam logic [2:0]  CTRL_RST    = 3'h0;

    localparam int          IN_W        = 8;
    localparam int          IN_D        = 0;
    localparam int          IN_SET      = 1;
    localparam int          IN_ZERO     = 2;
    localparam int          IN_CE       = 3;
    localparam int          IN_J        = 4;
    localparam int          IN_K        = 5;
    localparam int          IN_CLR      = 6;
    localparam int          IN_PRE      = 7;
    localparam logic [7:0]  IN_RST      = 8'h00;

    // ------------------------------------------------------------------
    // Elements
    // ------------------------------------------------------------------
    localparam int           NUM_ELEM   = 11;
    localparam int           E_DS       = 0;
    localparam int           E_DS_F     = 1;
    localparam int           E_DSE      = 2;
    localparam int           E_DSE_F    = 3;
    localparam int           E_DSR      = 4;
    localparam int           E_DSRE     = 5;
    localparam int           E_JKC      = 6;
    localparam int           E_JKCE     = 7;
    localparam int           E_JKCP     = 8;
    localparam int           E_JKCPE    = 9;
    localparam int           E_JKP      = 10;

    localparam logic [10:0]  JK_MASK    = 11'h7c0;
    localparam logic [10:0]  FALL_MASK  = 11'h00a;
    localparam logic [10:0]  CE_MASK    = 11'h2ac;
    localparam logic [10:0]  ZERO_MASK  = 11'h030;
    localparam logic [10:0]  CLR_MASK   = 11'h3c0;
    localparam logic [10:0]  PRE_MASK   = 11'h700;
    localparam logic [10:0]  INIT_MASK  = 11'h400;

    typedef enum logic [1:0] {
        SJK_SEL_CTRL,
        SJK_SEL_INPUT,
        SJK_SEL_STATE,
        SJK_SEL_NONE
    } sjk_sel_t;

endpackage

// File: verilog/sjk_cell.sv
/*
 * One storage element of the bank, D or J-K kind chosen by parameters.
 * Assumes tick is a one-cycle pulse marking the element's active clock
 * edge, and that all inputs are on the pclk domain.
 */
`timescale 1ns/1ns
module sjk_cell #(
    parameter bit IS_JK    = 1'b0,
    parameter bit HAS_CE   = 1'b0,
    parameter bit HAS_ZERO = 1'b0,
    parameter bit HAS_CLR  = 1'b0,
    parameter bit HAS_PRE  = 1'b0,
    parameter bit INIT_ONE = 1'b0
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic init_act,
    input  wire logic tick,
    input  wire logic d,
    input  wire logic set_one,
    input  wire logic set_zero,
    input  wire logic ce,
    input  wire logic j,
    input  wire logic k,
    input  wire logic clr,
    input  wire logic pre,
    output logic      q
);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic q_r;
    logic q_nxt;
    logic en;
    logic clr_on;
    logic pre_on;
    logic d_next;
    logic jk_next;

    assign en      = tick & (~HAS_CE | ce);
    assign clr_on  = HAS_CLR & clr;
    assign pre_on  = HAS_PRE & pre;
    // Set before zero before data
    assign d_next  = set_one ? 1'b1 :
                     (HAS_ZERO & set_zero) ? 1'b0 :
                     d;
    assign jk_next = ({j, k} == 2'b00) ? q_r :
                     ({j, k} == 2'b01) ? 1'b0 :
                     ({j, k} == 2'b10) ? 1'b1 : ~q_r;

    // Async inputs act on every cycle, not only on ticks
    assign q_nxt = init_act ? INIT_ONE :
                   clr_on   ? 1'b0 :
                   pre_on   ? 1'b1 :
                   (!IS_JK && tick && set_one) ? 1'b1 :
                   (!IS_JK && tick && HAS_ZERO && set_zero)
                            ? 1'b0 :
                   en ? (IS_JK ? jk_next : d_next) : q_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_r <= INIT_ONE;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule

// File: verilog/sjk_bank.sv
/*
 * Bank of eleven single-bit storage elements behind an APB slave.
 * Software drives the element clock, the data and control inputs and
 * the initialization net; the element outputs are read back and also
 * leave as ports. Assumes a single 125 MHz pclk and an APB3 master.
 */
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module sjk_bank
    import sjk_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [DATA_W-1:0]    pwdata,
    output logic      [DATA_W-1:0]    prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic      [NUM_ELEM-1:0]  elem_q
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W < 4 || ADDR_W > 12) begin : g_bad_addr
        $error("ADDR_W must be 4 to 12");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic sjk_sel_t reg_sel(input logic [ADDR_W-1:0] a);
        logic [11:0] wide;
        wide = 12'(a);
        if (wide == ADDR_CTRL) begin
            return SJK_SEL_CTRL;
        end else if (wide == ADDR_INPUT) begin
            return SJK_SEL_INPUT;
        end else if (wide == ADDR_STATE) begin
            return SJK_SEL_STATE;
        end
        return SJK_SEL_NONE;
    endfunction

    logic [CTRL_W-1:0]   ctl_r;
    logic [IN_W-1:0]     in_r;
    logic                clk_d_r;
    logic                pready_r;
    logic                pslverr_r;
    logic [DATA_W-1:0]   prdata_r;
    logic [NUM_ELEM-1:0] q_w;

    sjk_sel_t            sel;
    logic                setup;
    logic                access;
    logic                wr_ctl;
    logic                wr_in;
    logic [DATA_W-1:0]   rd_mux;

    assign sel    = reg_sel(paddr);
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready_r;
    assign wr_ctl = access & pwrite & (sel == SJK_SEL_CTRL);
    assign wr_in  = access & pwrite & (sel == SJK_SEL_INPUT);
    assign rd_mux = (sel == SJK_SEL_CTRL)  ? DATA_W'(ctl_r) :
                    (sel == SJK_SEL_INPUT) ? DATA_W'(in_r)  :
                    (sel == SJK_SEL_STATE) ? DATA_W'(q_w)   :
                    32'h0000_0000;

    // ------------------------------------------------------------------
    // APB answer, one wait-free access phase
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= setup;
            pslverr_r <= setup & (sel == SJK_SEL_NONE);
            prdata_r  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Control and input registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_r   <= CTRL_RST;
            in_r    <= IN_RST;
            clk_d_r <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl_r <= pwdata[CTRL_W-1:0];
            end
            if (wr_in) begin
                in_r <= pwdata[IN_W-1:0];
            end
            clk_d_r <= ctl_r[CTRL_CLK];
        end
    end

    // ------------------------------------------------------------------
    // Element clock edges and init net
    // ------------------------------------------------------------------
    // Edges of the software clock bit become one-cycle ticks; no real
    // second clock, so everything stays on pclk.
    logic tick_rise;
    logic tick_fall;
    logic init_act;

    assign tick_rise = ctl_r[CTRL_CLK] & ~clk_d_r;
    assign tick_fall = ~ctl_r[CTRL_CLK] & clk_d_r;
    assign init_act  = ctl_r[CTRL_INIT] ^ ctl_r[CTRL_INV];

    logic d_in;
    logic set_in;
    logic zero_in;
    logic ce_in;
    logic j_in;
    logic k_in;
    logic clr_in;
    logic pre_in;

    assign d_in    = in_r[IN_D];
    assign set_in  = in_r[IN_SET];
    assign zero_in = in_r[IN_ZERO];
    assign ce_in   = in_r[IN_CE];
    assign j_in    = in_r[IN_J];
    assign k_in    = in_r[IN_K];
    assign clr_in  = in_r[IN_CLR];
    assign pre_in  = in_r[IN_PRE];

    // ------------------------------------------------------------------
    // Element array
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NUM_ELEM; i++) begin : g_elem
        logic tick_i;
        assign tick_i = FALL_MASK[i] ? tick_fall : tick_rise;
        sjk_cell #(
            .IS_JK    (JK_MASK[i]),
            .HAS_CE   (CE_MASK[i]),
            .HAS_ZERO (ZERO_MASK[i]),
            .HAS_CLR  (CLR_MASK[i]),
            .HAS_PRE  (PRE_MASK[i]),
            .INIT_ONE (INIT_MASK[i])
        ) u_cell (
            .pclk     (pclk),
            .presetn  (presetn),
            .init_act (init_act),
            .tick     (tick_i),
            .d        (d_in),
            .set_one  (set_in),
            .set_zero (zero_in),
            .ce       (ce_in),
            .j        (j_in),
            .k        (k_in),
            .clr      (clr_in),
            .pre      (pre_in),
            .q        (q_w[i])
        );
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign elem_q  = q_w;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic rise_ok;
    logic fall_ok;
    logic async_ok;
    assign rise_ok  = tick_rise & ~init_act;
    assign fall_ok  = tick_fall & ~init_act;
    assign async_ok = ~init_act & ~clr_in & ~pre_in;

    set_one_a: assert property (
        rise_ok && set_in |=> q_w[E_DS])
        else $error("set did not drive q high");

    d_capture_a: assert property (
        rise_ok && !set_in |=> q_w[E_DS] == $past(d_in))
        else $error("data not captured on rising edge");

    fall_edge_a: assert property (
        !tick_fall && !init_act |=> $stable(q_w[E_DS_F]))
        else $error("falling element moved without falling edge");

    fall_load_a: assert property (
        fall_ok |=> q_w[E_DS_F] == $past(set_in | d_in))
        else $error("falling element wrong after falling edge");

    fall_init_a: assert property (
        init_act |=> !q_w[E_DS_F] && !q_w[E_DSE_F])
        else $error("init net did not clear falling elements");

    init_pol_a: assert property (
        ctl_r[CTRL_INIT] != ctl_r[CTRL_INV] |=> q_w[E_JKP] && !q_w[E_DS])
        else $error("init polarity not honoured");

    set_over_ce_a: assert property (
        rise_ok && set_in && !ce_in |=> q_w[E_DSE])
        else $error("set did not override low enable");

    ce_hold_a: assert property (
        rise_ok && !set_in && !ce_in |=> $stable(q_w[E_DSE]))
        else $error("enabled element moved with enable low");

    zero_prio_a: assert property (
        rise_ok && zero_in |=> q_w[E_DSR] == $past(set_in))
        else $error("set over zero priority broken");

    both_low_a: assert property (
        rise_ok && !set_in && !zero_in |=> q_w[E_DSR] == $past(d_in))
        else $error("set-zero element did not capture data");

    sre_hold_a: assert property (
        rise_ok && !set_in && !zero_in && !ce_in
        |=> $stable(q_w[E_DSRE]))
        else $error("set-zero-enable element loaded with enable low");

    clr_force_a: assert property (
        !init_act && clr_in |=> !q_w[E_JKC] && !q_w[E_JKCE])
        else $error("clear did not force q low");

    jk_toggle_a: assert property (
        rise_ok && !clr_in && j_in && k_in
        |=> q_w[E_JKC] != $past(q_w[E_JKC]))
        else $error("j-k toggle failed");

    jk_ce_hold_a: assert property (
        async_ok && !ce_in |=> $stable(q_w[E_JKCE]))
        else $error("j-k element moved with enable low");

    pre_force_a: assert property (
        !init_act && !clr_in && pre_in |=> q_w[E_JKCP] && q_w[E_JKCPE])
        else $error("preset did not force q high");

    cpe_hold_a: assert property (
        async_ok && !ce_in |=> $stable(q_w[E_JKCPE]))
        else $error("clear-preset element moved with enable low");

    pre_only_a: assert property (
        (init_act || pre_in) |=> q_w[E_JKP])
        else $error("preset-only element not high");

    clr_wins_a: assert property (
        !init_act && clr_in && pre_in |=> !q_w[E_JKCP] && !q_w[E_JKCPE])
        else $error("clear did not win over preset");

    // ------------------------------------------------------------------
    // Bus, register and extra element checks
    // ------------------------------------------------------------------
    ready_next_a: assert property (setup |=> pready_r)
        else $error("no ready after setup");

    ready_pulse_a: assert property (pready_r |=> !pready_r)
        else $error("ready stood longer than one cycle");

    rdata_idle_a: assert property (!pready_r |-> prdata_r == 32'h0000_0000)
        else $error("read data not zero outside answer");

    err_ready_a: assert property (pslverr_r |-> pready_r)
        else $error("error flag without ready");

    err_unmapped_a: assert property (setup && sel == SJK_SEL_NONE |=> pslverr_r)
        else $error("unmapped address not refused");

    ctl_hold_a: assert property (!wr_ctl |=> $stable(ctl_r))
        else $error("control word moved without write");

    in_hold_a: assert property (!wr_in |=> $stable(in_r))
        else $error("input word moved without write");

    ctl_write_a: assert property (
        wr_ctl |=> ctl_r == $past(pwdata[CTRL_W-1:0]))
        else $error("control write did not land");

    state_read_a: assert property (
        setup && !pwrite && sel == SJK_SEL_STATE
        |=> prdata_r[NUM_ELEM-1:0] == $past(q_w))
        else $error("state read gave wrong word");

    rise_hold_a: assert property (
        !tick_rise && !init_act |=> $stable(q_w[E_DS]))
        else $error("rising element moved without rising edge");

    fall_set_a: assert property (
        fall_ok && set_in |=> q_w[E_DSE_F])
        else $error("falling set did not drive q high");

    jk_clear_a: assert property (
        rise_ok && !clr_in && !j_in && k_in |=> !q_w[E_JKC])
        else $error("j-k clear code failed");

    jk_set_a: assert property (
        rise_ok && !clr_in && j_in && !k_in |=> q_w[E_JKC])
        else $error("j-k set code failed");

    sre_zero_a: assert property (
        rise_ok && !set_in && zero_in |=> !q_w[E_DSRE])
        else $error("zero ignored by set-zero-enable element");

    // Two rising ticks never meet back to back, so cover one alone
    toggle_c: cover property (rise_ok && !clr_in && j_in && k_in);
    wr_c: cover property (wr_in && pwdata[IN_CE]);
    fall_c: cover property (fall_ok && d_in && !set_in);
    clr_pre_c: cover property (!init_act && clr_in && pre_in);
    err_c: cover property (pslverr_r);

endmodule

// File: verif/tb_sjk_bank.sv
/*
 * Self-checking bench for the storage element bank behind APB.
 * Assumes element outputs settle within two cycles of the write that
 * causes them; waits for ready however long the slave takes.
 */
`timescale 1ns/1ns
module tb_sjk_bank
    import sjk_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals and expectation queue
    // ------------------------------------------------------------------
    typedef struct {
        logic        rd;
        logic [31:0] data;
        logic        err;
    } sjk_exp_t;

    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [11:0]         paddr;
    logic [31:0]         pwdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [NUM_ELEM-1:0] elem_q;
    sjk_exp_t            exp_q[$];
    int                  err_total;
    int                  checked;
    logic [10:0]         m;
    logic [2:0]          c;
    logic [7:0]          in_r;
    logic [31:0]         seed;

    sjk_bank #(.ADDR_W(12)) i_sjk_bank (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .elem_q  (elem_q)
    );

    always #4 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------------
    always @(posedge pclk) begin
        sjk_exp_t e;
        if (psel && penable && pready === 1'b1) begin
            checked++;
            if (exp_q.size() == 0) begin
                err_total++;
                $display("ERROR %0t unexpected answer", $time);
            end else begin
                e = exp_q.pop_front();
                if (pslverr !== e.err || (e.rd && prdata !== e.data)) begin
                    err_total++;
                    $display("ERROR %0t got %h/%b want %h/%b", $time,
                             prdata, pslverr, e.data, e.err);
                end
                if (e.rd && paddr == ADDR_STATE &&
                    elem_q !== e.data[NUM_ELEM-1:0]) begin
                    err_total++;
                    $display("ERROR %0t elem_q %h want %h", $time, elem_q,
                             e.data[NUM_ELEM-1:0]);
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus tasks and reference model
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, input logic [31:0] ex,
                       input logic er);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        exp_q.push_back(sjk_exp_t'{rd: !w, data: ex, err: er});
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
        // Idle cycle lets element outputs land before the next read
        @(posedge pclk);
    endtask

    // Model steps once per write; levels stay put between writes
    task automatic upd(input logic rise, input logic fall);
        for (int i = 0; i < NUM_ELEM; i++) begin
            if (c[CTRL_INIT] ^ c[CTRL_INV])
                m[i] = INIT_MASK[i];
            else if (in_r[IN_CLR] && CLR_MASK[i])
                m[i] = 1'b0;
            else if (in_r[IN_PRE] && PRE_MASK[i])
                m[i] = 1'b1;
            else if (FALL_MASK[i] ? fall : rise) begin
                if (!JK_MASK[i]) begin
                    if (in_r[IN_SET])
                        m[i] = 1'b1;
                    else if (in_r[IN_ZERO] && ZERO_MASK[i])
                        m[i] = 1'b0;
                    else if (!CE_MASK[i] || in_r[IN_CE])
                        m[i] = in_r[IN_D];
                end else if (!CE_MASK[i] || in_r[IN_CE]) begin
                    case ({in_r[IN_J], in_r[IN_K]})
                        2'b01: m[i] = 1'b0;
                        2'b10: m[i] = 1'b1;
                        2'b11: m[i] = ~m[i];
                        default: m[i] = m[i];
                    endcase
                end
            end
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic old_clk;
        old_clk = c[CTRL_CLK];
        apb(1'b1, a, d, 32'h0, 1'b0);
        if (a == ADDR_CTRL) begin
            c = d[2:0];
            upd(!old_clk && c[CTRL_CLK], old_clk && !c[CTRL_CLK]);
        end else if (a == ADDR_INPUT) begin
            in_r = d[7:0];
            upd(1'b0, 1'b0);
        end
    endtask

    task automatic rd_state();
        apb(1'b0, ADDR_STATE, {21'h0, m}, {21'h0, m}, 1'b0);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog and main sequence
    // ------------------------------------------------------------------
    initial begin
        #(8 * 40000);
        err_total++;
        $display("ERROR %0t watchdog expired", $time);
        results();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        err_total = 0;
        checked = 0;
        m = INIT_MASK;
        c = CTRL_RST;
        in_r = IN_RST;
        seed = 32'h5498b2e1;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_state();
        apb(1'b0, ADDR_CTRL, 32'h0, 32'h0, 1'b0);
        apb(1'b0, ADDR_INPUT, 32'h0, 32'h0, 1'b0);
        // Unmapped place is refused; status word ignores writes
        apb(1'b1, 12'h00c, 32'hffffffff, 32'h0, 1'b1);
        apb(1'b0, 12'h00c, 32'h0, 32'h0, 1'b1);
        apb(1'b1, ADDR_STATE, 32'h000007ff, 32'h0, 1'b0);
        rd_state();
        wr(ADDR_INPUT, 32'h000000ff);
        rd_state();
        wr(ADDR_INPUT, 32'h00000031);
        wr(ADDR_CTRL, 32'h00000001);
        rd_state();
        wr(ADDR_CTRL, 32'h00000004);
        rd_state();
        wr(ADDR_CTRL, 32'h00000006);
        rd_state();
        apb(1'b0, ADDR_CTRL, 32'h6, 32'h6, 1'b0);
        for (int it = 0; it < 400; it++) begin
            seed = xs(seed);
            wr(ADDR_INPUT, {24'h0, seed[7:0] & (seed[20] ? 8'hff : 8'h3f)});
            apb(1'b0, ADDR_INPUT, 32'h0, {24'h0, in_r}, 1'b0);
            wr(ADDR_CTRL, {29'h0, seed[16:13] == 4'h0,
                           seed[12:9] == 4'h0, seed[8]});
            rd_state();
            rd_state();
        end
        results();
    end
endmodule
